// file: design/port89_regs.vh
// Register offsets, reset values and bit positions of the port 8 / port 9 pin logic
`ifndef PORT89_REGS_VH
`define PORT89_REGS_VH

`define ADDR_PORT8_DATA        8'h10
`define ADDR_PORT8_DIR         8'h14
`define ADDR_PORT8_FSEL        8'h1c
`define ADDR_PORT9_DATA        8'h20
`define ADDR_PORT9_DIR         8'h24
`define ADDR_PORT9_FSEL        8'h28
`define ADDR_OPEN_DRAIN        8'h2c
`define ADDR_EXT_INT_MODE      8'h30

`define RST_PORT8_DATA         8'hff
`define RST_PORT8_DIR          8'h00
`define RST_PORT8_FSEL         8'h00
`define RST_PORT9_DATA         6'h3f
`define RST_PORT9_DIR          6'h00
`define RST_PORT9_FSEL         6'h00
`define RST_OPEN_DRAIN         2'h0
`define RST_EXT_INT_MODE       1'h0

`define FSEL8_MASK             8'h4c
`define BIT_TIMER_FF4          2
`define BIT_TIMER_FF5          3
`define BIT_TIMER_FF6          6
`define BIT_TIMER4_CLK_A       0
`define BIT_TIMER4_CLK_B       1
`define BIT_TIMER5_CLK_A       4
`define BIT_TIMER5_CLK_B       5
`define BIT_EXT_EXT_INTERRUPT0_PIN           7
`define BIT_SERIAL0_TRANSMIT_OUT               0
`define BIT_SERIAL0_RECEIVE_IN               1
`define BIT_CTS_SCLK0          2
`define BIT_SERIAL1_TRANSMIT_OUT               3
`define BIT_SERIAL1_RECEIVE_IN               4
`define BIT_SCLK1              5
`define BIT_OD_SERIAL0_TRANSMIT_OUT            0
`define BIT_OD_SERIAL1_TRANSMIT_OUT            1
`define BIT_EXT_EXT_INTERRUPT0_PIN_ENABLE    0

`define HTRANS_NONSEQ_BIT      1
`define WORD_ZERO              32'h0000_0000

`endif

// file: design/pin_cell.v
// One pin driver: port or function source, push-pull or open drain
`timescale 1ns/1ps
`default_nettype none

module pin_cell (
	input  wire sys_clk,
	input  wire rst_n,
	input  wire latch_value,
	input  wire port_drive,
	input  wire func_sel,
	input  wire func_value,
	input  wire func_drive,
	input  wire open_drain,
	output reg  pin_out,
	output reg  pin_oe,
	output reg  pin_pullup
);

	wire value;
	wire drive;
	wire oe;

	assign value = func_sel ? func_value : latch_value;
	assign drive = func_sel ? func_drive : port_drive;
	// Open drain only pulls low, so a high is a release
	assign oe    = open_drain ? (drive & ~value) : drive;

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			pin_out    <= 1'b1;
			pin_oe     <= 1'b0;
			pin_pullup <= 1'b1;
		end else begin
			pin_out    <= open_drain ? 1'b0 : value;
			pin_oe     <= oe;
			pin_pullup <= ~drive;
		end
	end

endmodule // pin_cell

`default_nettype wire

// file: design/port89_pins.v
// Port 8 and port 9 pin logic with AHB-Lite register access
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "port89_regs.vh"

module port89_pins (
	input  wire        sys_clk,
	input  wire        rst_n,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	input  wire [7:0]  port8_pin_in,
	output wire [7:0]  port8_pin_out,
	output wire [7:0]  port8_pin_oe,
	output wire [7:0]  port8_pin_pullup,
	input  wire [5:0]  port9_pin_in,
	output wire [5:0]  port9_pin_out,
	output wire [5:0]  port9_pin_oe,
	output wire [5:0]  port9_pin_pullup,
	input  wire        timer_ff4_output,
	input  wire        timer_ff5_output,
	input  wire        timer_ff6_output,
	output reg  [3:0]  timer_clock_in,
	output reg         ext_interrupt0_pin,
	input  wire        serial0_transmit_out,
	input  wire        serial1_transmit_out,
	output reg         serial0_receive_in,
	output reg         serial1_receive_in,
	output reg         serial0_clear_to_send,
	input  wire        serial0_clock_out,
	input  wire        serial0_clock_oe,
	output reg         serial0_clock_in,
	input  wire        serial1_clock_out,
	input  wire        serial1_clock_oe,
	output reg         serial1_clock_in
);

	reg  [7:0] port8_data;
	reg  [7:0] port8_direction_control;
	reg  [7:0] port8_function_select;
	reg  [5:0] port9_data;
	reg  [5:0] port9_direction_control;
	reg  [5:0] port9_function_select;
	reg  [1:0] open_drain_enable;
	reg        ext_ext_interrupt0_pin_enable;

	reg  [7:0] p8_meta;
	reg  [7:0] p8_sync;
	reg  [5:0] p9_meta;
	reg  [5:0] p9_sync;

	reg        wr_pending;
	reg  [7:0] wr_addr;
	reg  [31:0] next_hrdata;

	wire       addr_phase;
	wire [7:0] port8_level;
	wire [5:0] port9_level;
	wire [7:0] p8_func_value;
	wire [7:0] p8_func_drive;
	wire [5:0] p9_func_value;
	wire [5:0] p9_func_drive;
	wire [5:0] p9_od;

	assign addr_phase = hsel & hready & htrans[`HTRANS_NONSEQ_BIT];

	// Pins are asynchronous; two flops before any logic reads them
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			p8_meta <= 8'h00;
			p8_sync <= 8'h00;
			p9_meta <= 6'h00;
			p9_sync <= 6'h00;
		end else begin
			p8_meta <= port8_pin_in;
			p8_sync <= p8_meta;
			p9_meta <= port9_pin_in;
			p9_sync <= p9_meta;
		end
	end

	// Readback shows the latch for outputs, the pin level for inputs
	assign port8_level = (port8_data & port8_direction_control) |
		(p8_sync & ~port8_direction_control);
	assign port9_level = (port9_data & port9_direction_control) |
		(p9_sync & ~port9_direction_control);

	// Bus slave: zero wait states, response always OKAY
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			wr_pending <= 1'b0;
			wr_addr    <= 8'h00;
			hrdata     <= `WORD_ZERO;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
		end else begin
			wr_pending <= addr_phase & hwrite;
			wr_addr    <= haddr[7:0];
			hrdata     <= next_hrdata;
			hreadyout  <= 1'b1;
			hresp      <= 1'b0;
		end
	end

	always @* begin
		next_hrdata = `WORD_ZERO;
		if (addr_phase && !hwrite) begin
			case (haddr[7:0])
				`ADDR_PORT8_DATA:   next_hrdata = {24'h00_0000, port8_level};
				`ADDR_PORT9_DATA:   next_hrdata = {26'h000_0000, port9_level};
				`ADDR_PORT9_FSEL:   next_hrdata = {26'h000_0000, port9_function_select};
				`ADDR_OPEN_DRAIN:   next_hrdata = {30'h0000_0000, open_drain_enable};
				// Direction, port 8 select and interrupt mode are write-only
				default:            next_hrdata = `WORD_ZERO;
			endcase
		end
	end

	// Register writes land in the data phase, one register per process
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			port8_data <= `RST_PORT8_DATA;
		end else if (wr_pending && wr_addr == `ADDR_PORT8_DATA) begin
			port8_data <= hwdata[7:0];
		end
	end

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			port8_direction_control <= `RST_PORT8_DIR;
		end else if (wr_pending && wr_addr == `ADDR_PORT8_DIR) begin
			port8_direction_control <= hwdata[7:0];
		end
	end

	// Only bits 2, 3 and 6 exist; others stay zero
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			port8_function_select <= `RST_PORT8_FSEL;
		end else if (wr_pending && wr_addr == `ADDR_PORT8_FSEL) begin
			port8_function_select <= hwdata[7:0] & `FSEL8_MASK;
		end
	end

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			port9_data <= `RST_PORT9_DATA;
		end else if (wr_pending && wr_addr == `ADDR_PORT9_DATA) begin
			port9_data <= hwdata[5:0];
		end
	end

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			port9_direction_control <= `RST_PORT9_DIR;
		end else if (wr_pending && wr_addr == `ADDR_PORT9_DIR) begin
			port9_direction_control <= hwdata[5:0];
		end
	end

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			port9_function_select <= `RST_PORT9_FSEL;
		end else if (wr_pending && wr_addr == `ADDR_PORT9_FSEL) begin
			port9_function_select <= hwdata[5:0];
		end
	end

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			open_drain_enable <= `RST_OPEN_DRAIN;
		end else if (wr_pending && wr_addr == `ADDR_OPEN_DRAIN) begin
			open_drain_enable <= hwdata[1:0];
		end
	end

	// Software owns the enable half of the interrupt setup
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			ext_ext_interrupt0_pin_enable <= `RST_EXT_INT_MODE;
		end else if (wr_pending && wr_addr == `ADDR_EXT_INT_MODE) begin
			ext_ext_interrupt0_pin_enable <= hwdata[`BIT_EXT_EXT_INTERRUPT0_PIN_ENABLE];
		end
	end

	// Timer outputs need the direction bit as well as the select
	// Input-only pins have no function source; tie them off
	assign p8_func_value[`BIT_TIMER4_CLK_A] = 1'b0;
	assign p8_func_value[`BIT_TIMER4_CLK_B] = 1'b0;
	assign p8_func_value[`BIT_TIMER_FF4]    = timer_ff4_output;
	assign p8_func_value[`BIT_TIMER_FF5]    = timer_ff5_output;
	assign p8_func_value[`BIT_TIMER5_CLK_A] = 1'b0;
	assign p8_func_value[`BIT_TIMER5_CLK_B] = 1'b0;
	assign p8_func_value[`BIT_TIMER_FF6]    = timer_ff6_output;
	assign p8_func_value[`BIT_EXT_EXT_INTERRUPT0_PIN]     = 1'b0;
	assign p8_func_drive = port8_direction_control;

	// Transmit data and serial clocks; receive pins hold a harmless one
	assign p9_func_value[`BIT_SERIAL0_TRANSMIT_OUT]      = serial0_transmit_out;
	assign p9_func_value[`BIT_SERIAL0_RECEIVE_IN]      = 1'b1;
	assign p9_func_value[`BIT_CTS_SCLK0] = serial0_clock_out;
	assign p9_func_value[`BIT_SERIAL1_TRANSMIT_OUT]      = serial1_transmit_out;
	assign p9_func_value[`BIT_SERIAL1_RECEIVE_IN]      = 1'b1;
	assign p9_func_value[`BIT_SCLK1]     = serial1_clock_out;

	// Receive pins never drive in function mode; the clear-to-send / SCLK0 pin drives with serial0_clock_oe
	assign p9_func_drive[`BIT_SERIAL0_TRANSMIT_OUT]      = 1'b1;
	assign p9_func_drive[`BIT_SERIAL0_RECEIVE_IN]      = 1'b0;
	assign p9_func_drive[`BIT_CTS_SCLK0] = serial0_clock_oe;
	assign p9_func_drive[`BIT_SERIAL1_TRANSMIT_OUT]      = 1'b1;
	assign p9_func_drive[`BIT_SERIAL1_RECEIVE_IN]      = 1'b0;
	assign p9_func_drive[`BIT_SCLK1]     = serial1_clock_oe;

	// Open drain exists only on the two transmit pins
	assign p9_od[`BIT_SERIAL0_TRANSMIT_OUT]      = open_drain_enable[`BIT_OD_SERIAL0_TRANSMIT_OUT];
	assign p9_od[`BIT_SERIAL0_RECEIVE_IN]      = 1'b0;
	assign p9_od[`BIT_CTS_SCLK0] = 1'b0;
	assign p9_od[`BIT_SERIAL1_TRANSMIT_OUT]      = open_drain_enable[`BIT_OD_SERIAL1_TRANSMIT_OUT];
	assign p9_od[`BIT_SERIAL1_RECEIVE_IN]      = 1'b0;
	assign p9_od[`BIT_SCLK1]     = 1'b0;

	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : g_port8
			pin_cell u_cell (
				.sys_clk     (sys_clk),
				.rst_n       (rst_n),
				.latch_value (port8_data[i]),
				.port_drive  (port8_direction_control[i]),
				.func_sel    (port8_function_select[i]),
				.func_value  (p8_func_value[i]),
				.func_drive  (p8_func_drive[i]),
				.open_drain  (1'b0),
				.pin_out     (port8_pin_out[i]),
				.pin_oe      (port8_pin_oe[i]),
				.pin_pullup  (port8_pin_pullup[i])
			);
		end
		for (i = 0; i < 6; i = i + 1) begin : g_port9
			pin_cell u_cell (
				.sys_clk     (sys_clk),
				.rst_n       (rst_n),
				.latch_value (port9_data[i]),
				.port_drive  (port9_direction_control[i]),
				.func_sel    (port9_function_select[i]),
				.func_value  (p9_func_value[i]),
				.func_drive  (p9_func_drive[i]),
				.open_drain  (p9_od[i]),
				.pin_out     (port9_pin_out[i]),
				.pin_oe      (port9_pin_oe[i]),
				.pin_pullup  (port9_pin_pullup[i])
			);
		end
	endgenerate

	// Input functions other than interrupt 0 track the pin whatever the select says
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			timer_clock_in        <= 4'h0;
			ext_interrupt0_pin    <= 1'b0;
			serial0_receive_in    <= 1'b1;
			serial1_receive_in    <= 1'b1;
			serial0_clear_to_send <= 1'b1;
			serial0_clock_in      <= 1'b1;
			serial1_clock_in      <= 1'b1;
		end else begin
			timer_clock_in <= {p8_sync[`BIT_TIMER5_CLK_B], p8_sync[`BIT_TIMER5_CLK_A],
				p8_sync[`BIT_TIMER4_CLK_B], p8_sync[`BIT_TIMER4_CLK_A]};
			// Gated so a pin left as output never raises interrupt 0
			ext_interrupt0_pin <= p8_sync[`BIT_EXT_EXT_INTERRUPT0_PIN] & ext_ext_interrupt0_pin_enable &
				~port8_direction_control[`BIT_EXT_EXT_INTERRUPT0_PIN];
			serial0_receive_in    <= p9_sync[`BIT_SERIAL0_RECEIVE_IN];
			serial1_receive_in    <= p9_sync[`BIT_SERIAL1_RECEIVE_IN];
			serial0_clear_to_send <= p9_sync[`BIT_CTS_SCLK0];
			serial0_clock_in      <= p9_sync[`BIT_CTS_SCLK0];
			serial1_clock_in      <= p9_sync[`BIT_SCLK1];
		end
	end

endmodule // port89_pins

`default_nettype wire

// file: test/port89_pins_sva.sv
// Checker for the port 8 / port 9 pin logic
`timescale 1ns/1ps
`default_nettype none
`include "port89_regs.vh"
module port89_chk (
	input wire logic        sys_clk,
	input wire logic        rst_n,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [7:0]  port8_pin_in,
	input wire logic [5:0]  port9_pin_in,
	input wire logic [5:0]  port9_pin_out,
	input wire logic [5:0]  port9_pin_oe,
	input wire logic [5:0]  port9_pin_pullup,
	input wire logic        serial0_transmit_out,
	input wire logic        serial1_transmit_out,
	input wire logic [3:0]  timer_clock_in,
	input wire logic        ext_interrupt0_pin,
	input wire logic        serial0_receive_in,
	input wire logic        serial1_receive_in,
	input wire logic        serial0_clear_to_send,
	input wire logic        serial0_clock_in
);
	logic [2:0] age;
	logic       pend;
	logic [7:0] wa;
	logic [5:0] fsel;
	logic [1:0] od;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Shadow of the serial setup; age covers the three-edge input pipeline
	always_ff @(posedge sys_clk) begin
		pend <= rst_n && hsel && hready && htrans[1] && hwrite;
		wa <= haddr[7:0];
		if (!rst_n) begin
			age <= 3'h0;
			fsel <= 6'h00;
			od <= 2'h0;
		end else begin
			if (age != 3'h4)
				age <= age + 3'h1;
			if (pend && wa == `ADDR_PORT9_FSEL)
				fsel <= hwdata[5:0];
			if (pend && wa == `ADDR_OPEN_DRAIN)
				od <= hwdata[1:0];
		end
	end
	chk_timer_clk_follow: assert property (age == 3'h4 |-> timer_clock_in ==
		{$past(port8_pin_in[5], 3), $past(port8_pin_in[4], 3),
		$past(port8_pin_in[1], 3), $past(port8_pin_in[0], 3)}) else $error("timer clock lag");
	chk_rx_follow: assert property (age == 3'h4 |->
		serial0_receive_in == $past(port9_pin_in[1], 3) &&
		serial1_receive_in == $past(port9_pin_in[4], 3)) else $error("receive input lag");
	chk_cts_clock_in: assert property (age == 3'h4 |->
		serial0_clear_to_send == $past(port9_pin_in[2], 3) &&
		serial0_clock_in == serial0_clear_to_send) else $error("clear to send lag");
	chk_reset_pins: assert property ($rose(rst_n) |-> port9_pin_oe == 6'h00 &&
		port9_pin_pullup == 6'h3f && port9_pin_out == 6'h3f) else $error("pin reset state");
	chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus stall or error");
	chk_ext_int_level: assert property (age == 3'h4 && ext_interrupt0_pin |->
		$past(port8_pin_in[7], 3)) else $error("interrupt without pin");
	chk_tx0_push: assert property (fsel[0] && !od[0] |=> port9_pin_oe[0] &&
		port9_pin_out[0] == $past(serial0_transmit_out)) else $error("transmit 0 route");
	chk_tx1_drain: assert property (fsel[3] && od[1] |=>
		port9_pin_oe[3] == !$past(serial1_transmit_out) &&
		!(port9_pin_oe[3] && port9_pin_out[3])) else $error("transmit 1 open drain");
	cover property (fsel[0] && !od[0]);
	cover property (fsel[3] && od[1]);
	cover property (ext_interrupt0_pin);
endmodule // port89_chk
bind port89_pins port89_chk u_chk (.*);
`default_nettype wire

// file: test/pin_world.sv
// External pin model: device drive, outside drive, pull-up or floating
`timescale 1ns/1ps
`default_nettype none
module pin_world #(
	parameter int W = 8
) (
	input  wire logic         sys_clk,
	input  wire logic [W-1:0] pin_out,
	input  wire logic [W-1:0] pin_oe,
	input  wire logic [W-1:0] pin_pullup,
	input  wire logic [W-1:0] ext_val,
	input  wire logic [W-1:0] ext_en,
	output var  logic [W-1:0] pin_in
);
	logic [W-1:0] wobble = '0;
	// A floating line must not settle where the simulator likes
	always @(posedge sys_clk) wobble <= ~wobble;
	always_comb
		for (int i = 0; i < W; i++)
			pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
				pin_pullup[i] ? 1'b1 : wobble[i];
endmodule // pin_world
`default_nettype wire

// file: test/port89_pins_bench.sv
// Random and corner tests of the port 8 / port 9 pin logic
`timescale 1ns/1ps
`default_nettype none
`include "port89_regs.vh"
module port89_pins_bench;
	logic        sys_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
	logic        hreadyout, hresp, ext_interrupt0_pin, serial0_receive_in, serial1_receive_in;
	logic        serial0_clear_to_send, serial0_clock_in, serial1_clock_in;
	logic        timer_ff4_output = 1'b0, timer_ff5_output = 1'b0, timer_ff6_output = 1'b0;
	logic        serial0_transmit_out = 1'b0, serial1_transmit_out = 1'b0;
	logic        serial0_clock_out = 1'b0, serial0_clock_oe = 1'b0;
	logic        serial1_clock_out = 1'b0, serial1_clock_oe = 1'b0;
	logic [3:0]  timer_clock_in;
	logic [7:0]  port8_pin_in, port8_pin_out, port8_pin_oe, port8_pin_pullup;
	logic [5:0]  port9_pin_in, port9_pin_out, port9_pin_oe, port9_pin_pullup;
	logic [7:0]  p8_val = 8'h00, p8_en = 8'hff;
	logic [5:0]  p9_val = 6'h00, p9_en = 6'h3f;
	int          num_errors = 0;
	int          num_checks = 0;
	always #12.5 sys_clk = ~sys_clk;
	port89_pins u_port89_pins (.*, .hsize(3'h2), .hready(hreadyout));
	pin_world #(.W(8)) u_pin_world8 (.sys_clk(sys_clk), .pin_out(port8_pin_out),
		.pin_oe(port8_pin_oe), .pin_pullup(port8_pin_pullup), .ext_val(p8_val),
		.ext_en(p8_en), .pin_in(port8_pin_in));
	pin_world #(.W(6)) u_pin_world6 (.sys_clk(sys_clk), .pin_out(port9_pin_out),
		.pin_oe(port9_pin_oe), .pin_pullup(port9_pin_pullup), .ext_val(p9_val),
		.ext_en(p9_en), .pin_in(port9_pin_in));
	// Entered just after a rising edge; leaves just after the data-phase edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'h2;
		hwrite <= w;
		@(posedge sys_clk);
		while (hreadyout !== 1'b1) @(posedge sys_clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge sys_clk);
		while (hreadyout !== 1'b1) @(posedge sys_clk);
		rd = hrdata;
	endtask
	task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	// Expected {drive enable, driven level} of a transmit pin
	function automatic logic [1:0] tx_pin(input logic od, input logic tx);
		return od ? {~tx, 1'b0} : {1'b1, tx};
	endfunction
	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk);
		num_errors++;
		summarize();
	end
	initial begin
		logic [5:0] d;
		logic [5:0] v;
		void'($urandom(32'h0f59));
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		check("p9 reset", {6'h00, 6'h3f, 6'h3f}, {port9_pin_oe, port9_pin_pullup, port9_pin_out});
		bus(1'b0, `ADDR_PORT9_FSEL, '0);
		check("p9 fsel", 32'h0000_0000, rd);
		bus(1'b0, 8'h3c, '0);
		check("unmapped", 32'h0000_0000, rd);
		bus(1'b1, `ADDR_EXT_INT_MODE, 32'h0000_0001);
		for (int i = 0; i < 10; i++) begin
			p8_val <= (i == 0) ? 8'h33 : 8'($urandom);
			p9_val <= (i == 0) ? 6'h2a : 6'($urandom);
			repeat (5) @(posedge sys_clk);
			check("timer clk", {p8_val[5:4], p8_val[1:0]}, timer_clock_in);
			check("ext_interrupt0_pin", p8_val[7], ext_interrupt0_pin);
			check("serial in", {p9_val[5], {2{p9_val[2]}}, p9_val[4], p9_val[1]}, {serial1_clock_in,
				serial0_clock_in, serial0_clear_to_send, serial1_receive_in, serial0_receive_in});
		end
		bus(1'b1, `ADDR_PORT8_DIR, 32'h0000_004c);
		bus(1'b1, `ADDR_PORT8_DATA, 32'h0000_0000);
		bus(1'b1, `ADDR_PORT8_FSEL, 32'h0000_00ff);
		for (int i = 0; i < 8; i++) begin
			{timer_ff6_output, timer_ff5_output, timer_ff4_output} <= 3'($urandom);
			repeat (3) @(posedge sys_clk);
			check("timer out", {1'b0, timer_ff6_output, 2'h0, timer_ff5_output, timer_ff4_output,
				2'h0}, port8_pin_out & 8'h4c);
		end
		bus(1'b1, `ADDR_PORT8_FSEL, 32'h0000_0000);
		repeat (2) @(posedge sys_clk);
		check("p8 port", {8'h4c, 8'hb3, 8'h00}, {port8_pin_oe, port8_pin_pullup,
			port8_pin_out & 8'h4c});
		for (int i = 0; i < 8; i++) begin
			d = (i == 0) ? 6'h3f : 6'($urandom);
			v = (i == 0) ? 6'h00 : 6'($urandom);
			bus(1'b1, `ADDR_PORT9_DIR, {26'h000_0000, d});
			bus(1'b1, `ADDR_PORT9_DATA, {26'h000_0000, v});
			repeat (2) @(posedge sys_clk);
			check("p9 dir", {d, v & d}, {port9_pin_oe, port9_pin_out & d});
		end
		bus(1'b1, `ADDR_PORT9_DIR, 32'h0000_0000);
		bus(1'b1, `ADDR_PORT9_FSEL, 32'h0000_002d);
		bus(1'b0, `ADDR_PORT9_FSEL, '0);
		check("fsel back", 32'h0000_002d, rd);
		for (int m = 0; m < 4; m++) begin
			bus(1'b1, `ADDR_OPEN_DRAIN, 32'(m));
			for (int i = 0; i < 4; i++) begin
				{serial1_clock_out, serial1_clock_oe, serial1_transmit_out, serial0_transmit_out,
					serial0_clock_out, serial0_clock_oe} <= 6'($urandom);
				repeat (3) @(posedge sys_clk);
				check("tx0", tx_pin(m[0], serial0_transmit_out),
					{port9_pin_oe[0], port9_pin_out[0] & port9_pin_oe[0]});
				check("tx1", tx_pin(m[1], serial1_transmit_out),
					{port9_pin_oe[3], port9_pin_out[3] & port9_pin_oe[3]});
				check("sclk0", {serial0_clock_oe, serial0_clock_out & serial0_clock_oe},
					{port9_pin_oe[2], port9_pin_out[2] & port9_pin_oe[2]});
				check("sclk1", {serial1_clock_oe, serial1_clock_out & serial1_clock_oe},
					{port9_pin_oe[5], port9_pin_out[5] & port9_pin_oe[5]});
				check("rx release", 2'h0, {port9_pin_oe[4], port9_pin_oe[1]});
			end
		end
		summarize();
	end
endmodule // port89_pins_bench
`default_nettype wire
